// ### tmf_core.v
`include "tmf_defines.vh"

module tmf_core #(
  parameter FAIL_TICKS = `TMF_FAIL_TICKS,
  parameter OOC_TICKS = `TMF_OOC_TICKS
) (
  // Clock and reset.
  input wire i_mclk,
  input wire i_rst,
  // Command register port.
  input wire [7:0] i_cmd_addr,
  input wire [7:0] i_cmd_wdata,
  input wire i_cmd_wr,
  input wire i_cmd_rd,
  output reg [7:0] o_cmd_rdata,
  input wire i_alert_ack,
  // Analog front end.
  output reg o_adc_start,
  output reg [1:0] o_adc_chan,
  input wire i_adc_done,
  input wire [10:0] i_adc_result,
  input wire [2:0] i_diode_open,
  input wire [2:0] i_diode_short,
  input wire [3:0] i_hw_threshold_code,
  // Results.
  output reg [10:0] o_temp_first,
  output reg [10:0] o_temp_second,
  output reg [10:0] o_temp_third,
  // Fan pins.
  input wire i_fan_clk,
  input wire i_tachometer_input,
  output reg [7:0] o_fan_drive_output,
  output reg [4:0] o_pulses_per_rev,
  // Open-drain outputs.
  output wire o_shutdown_output_o,
  output wire o_shutdown_output_oe,
  output wire o_alert_o,
  output wire o_alert_oe
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Adds a half-degree offset and clamps instead of wrapping round.
  function [10:0] add_offset;
    input [10:0] raw;
    input [3:0] off;
    reg [11:0] sum;
    begin
      sum = {raw[10], raw} + {{6{off[3]}}, off, 2'b00};
      if (sum[11] != sum[10])
        add_offset = sum[11] ? 11'h400 : 11'h3FF;
      else
        add_offset = sum[10:0];
    end
  endfunction

  // Free-running interval in fan clock ticks for a rate code.
  function [19:0] rate_ticks;
    input [2:0] code;
    begin
      rate_ticks = `TMF_FAST_INTERVAL_TICKS << (3'd7 - code);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] config_reg;
  reg [7:0] rate_reg;
  reg [7:0] target_reg;
  reg [7:0] open_level_reg;
  reg [3:0] offset_reg [0:2];
  reg [1:0] ppr_reg;
  reg [2:0] queue_reg;
  reg [7:0] crit1_reg;
  reg [7:0] crit3_reg;
  reg [2:0] open_fault_reg;
  reg fan_fail_reg;
  reg ooc_reg;
  reg alert_reg;
  reg [2:0] shdn_reg;
  reg [3:0] queue_cnt_reg [0:2];
  reg [7:0] measured_reg;
  reg one_shot_reg;
  wire busy;
  wire [7:0] status;
  wire wr_status_rd;
  wire start_take;
  reg fail_event;
  reg ooc_event;
  integer i;
  integer j;
  integer k;

  assign status = {busy, fan_fail_reg, ooc_reg, 1'b0, open_fault_reg, 1'b0};
  assign wr_status_rd = i_cmd_rd && (i_cmd_addr == `TMF_CMD_STATUS);

  // Register writes; a one-shot write while stopped is held until the sequencer takes it.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      config_reg <= `TMF_RST_CONFIG;
      rate_reg <= `TMF_RST_RATE;
      target_reg <= `TMF_RST_TARGET;
      open_level_reg <= 8'h00;
      for (j = 0; j < 3; j = j + 1)
        offset_reg[j] <= 4'h0;
      ppr_reg <= 2'h0;
      queue_reg <= 3'h0;
      crit1_reg <= `TMF_RST_CRIT;
      crit3_reg <= `TMF_RST_CRIT;
      one_shot_reg <= 1'b0;
    end else begin
      if (start_take)
        one_shot_reg <= 1'b0;
      if (i_cmd_wr) begin
        case (i_cmd_addr)
          `TMF_CMD_CONFIG: config_reg <= i_cmd_wdata;
          `TMF_CMD_RATE: rate_reg <= i_cmd_wdata;
          `TMF_CMD_ONE_SHOT: one_shot_reg <= config_reg[`TMF_CFG_STOP];
          `TMF_CMD_TARGET: target_reg <= i_cmd_wdata;
          `TMF_CMD_OPEN_LEVEL: open_level_reg <= i_cmd_wdata;
          `TMF_CMD_OFFSET1: offset_reg[0] <= i_cmd_wdata[3:0];
          `TMF_CMD_OFFSET2: offset_reg[1] <= i_cmd_wdata[3:0];
          `TMF_CMD_OFFSET3: offset_reg[2] <= i_cmd_wdata[3:0];
          `TMF_CMD_PPR: ppr_reg <= i_cmd_wdata[1:0];
          `TMF_CMD_QUEUE: queue_reg <= i_cmd_wdata[2:0];
          `TMF_CMD_CRIT1: crit1_reg <= i_cmd_wdata;
          `TMF_CMD_CRIT3: crit3_reg <= i_cmd_wdata;
          default: ;
        endcase
      end
    end
  end

  // Read data is registered: it appears the cycle after the read strobe.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_cmd_rdata <= 8'h00;
    end else if (i_cmd_rd) begin
      case (i_cmd_addr)
        `TMF_CMD_STATUS: o_cmd_rdata <= status;
        `TMF_CMD_CONFIG: o_cmd_rdata <= config_reg;
        `TMF_CMD_SHDN_STATUS: o_cmd_rdata <= {5'h00, shdn_reg};
        `TMF_CMD_RATE: o_cmd_rdata <= rate_reg;
        `TMF_CMD_TARGET: o_cmd_rdata <= target_reg;
        `TMF_CMD_MEASURED: o_cmd_rdata <= measured_reg;
        `TMF_CMD_OPEN_LEVEL: o_cmd_rdata <= open_level_reg;
        `TMF_CMD_OFFSET1: o_cmd_rdata <= {4'h0, offset_reg[0]};
        `TMF_CMD_OFFSET2: o_cmd_rdata <= {4'h0, offset_reg[1]};
        `TMF_CMD_OFFSET3: o_cmd_rdata <= {4'h0, offset_reg[2]};
        `TMF_CMD_PPR: o_cmd_rdata <= {6'h00, ppr_reg};
        `TMF_CMD_QUEUE: o_cmd_rdata <= {5'h00, queue_reg};
        `TMF_CMD_CRIT1: o_cmd_rdata <= crit1_reg;
        `TMF_CMD_CRIT3: o_cmd_rdata <= crit3_reg;
        default: o_cmd_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------

  // Three stages; a level counts once stages two and three agree.
  reg [2:0] clk_sync_reg;
  reg [2:0] tach_sync_reg;
  reg clk_level_reg;
  reg tach_level_reg;
  wire tick;
  wire tach_fall;
  wire tach_change;

  assign tick = (clk_sync_reg[1] == clk_sync_reg[2]) && clk_sync_reg[2] && !clk_level_reg;
  assign tach_change = (tach_sync_reg[1] == tach_sync_reg[2]) &&
                       (tach_sync_reg[2] != tach_level_reg);
  assign tach_fall = tach_change && !tach_sync_reg[2];

  always @(posedge i_mclk) begin
    if (i_rst) begin
      clk_sync_reg <= 3'h0;
      tach_sync_reg <= 3'h7;
      clk_level_reg <= 1'b0;
      tach_level_reg <= 1'b1;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], i_fan_clk};
      tach_sync_reg <= {tach_sync_reg[1:0], i_tachometer_input};
      if (clk_sync_reg[1] == clk_sync_reg[2])
        clk_level_reg <= clk_sync_reg[2];
      if (tach_sync_reg[1] == tach_sync_reg[2])
        tach_level_reg <= tach_sync_reg[2];
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SAMPLE = 3'd1;
  localparam [2:0] ST_REQ = 3'd2;
  localparam [2:0] ST_WAIT = 3'd3;
  localparam [2:0] ST_PUBLISH = 3'd4;

  reg [2:0] state_reg;
  reg [19:0] interval_reg;
  reg [10:0] shadow_reg [0:2];
  reg [2:0] open_smp_reg;
  reg [2:0] short_smp_reg;
  wire timer_due;
  wire [7:0] hw_limit;
  wire [2:0] over;

  // The interval timer counts in every mode but can only expire while free-running conversion is enabled.
  assign timer_due = !config_reg[`TMF_CFG_STOP] && (interval_reg >= rate_ticks(rate_reg[2:0]));
  assign start_take = (state_reg == ST_IDLE) && (timer_due || one_shot_reg);
  assign busy = (state_reg != ST_IDLE);
  assign hw_limit = `TMF_HW_BASE + {3'h0, i_hw_threshold_code, 1'b0};

  // Integer parts compare as signed bytes.
  assign over[0] = $signed(o_temp_first[10:3]) > $signed(crit1_reg);
  assign over[1] = $signed(o_temp_second[10:3]) >= $signed(hw_limit);
  assign over[2] = $signed(o_temp_third[10:3]) > $signed(crit3_reg);

  always @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      interval_reg <= 20'h00000;
      o_adc_start <= 1'b0;
      o_adc_chan <= 2'd0;
      open_smp_reg <= 3'h0;
      short_smp_reg <= 3'h0;
      open_fault_reg <= 3'h0;
      for (k = 0; k < 3; k = k + 1)
        shadow_reg[k] <= 11'h000;
      o_temp_first <= 11'h000;
      o_temp_second <= 11'h000;
      o_temp_third <= 11'h000;
    end else begin
      o_adc_start <= 1'b0;
      if (start_take)
        interval_reg <= 20'h00000;
      else if (tick && !timer_due)
        interval_reg <= interval_reg + 20'h00001;
      case (state_reg)
        ST_IDLE: begin
          if (start_take)
            state_reg <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          // Detectors are read once per sequence; bits 3..1 hold sensors 1..3.
          open_smp_reg <= i_diode_open;
          short_smp_reg <= i_diode_short;
          open_fault_reg <= {i_diode_open[0], i_diode_open[1], i_diode_open[2]};
          o_adc_chan <= 2'd0;
          state_reg <= ST_REQ;
        end
        ST_REQ: begin
          o_adc_start <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (i_adc_done) begin
            if (short_smp_reg[o_adc_chan])
              shadow_reg[o_adc_chan] <= `TMF_SHORT_VALUE;
            else if (open_smp_reg[o_adc_chan])
              shadow_reg[o_adc_chan] <= shadow_reg[o_adc_chan];
            else
              shadow_reg[o_adc_chan] <= add_offset(i_adc_result, offset_reg[o_adc_chan]);
            if (o_adc_chan == 2'd2) begin
              state_reg <= ST_PUBLISH;
            end else begin
              o_adc_chan <= o_adc_chan + 2'd1;
              state_reg <= ST_REQ;
            end
          end
        end
        ST_PUBLISH: begin
          // All three results change in the same cycle.
          o_temp_first <= shadow_reg[0];
          o_temp_second <= shadow_reg[1];
          o_temp_third <= shadow_reg[2];
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Thermal shutdown
  // ----------------------------------------

  // Evaluated once per published result; a result in limit restarts the queue.
  reg publish_d_reg;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      publish_d_reg <= 1'b0;
      shdn_reg <= 3'h0;
      for (i = 0; i < 3; i = i + 1)
        queue_cnt_reg[i] <= 4'h0;
    end else begin
      publish_d_reg <= (state_reg == ST_PUBLISH);
      if (publish_d_reg) begin
        for (i = 0; i < 3; i = i + 1) begin
          if (!over[i]) begin
            queue_cnt_reg[i] <= 4'h0;
            shdn_reg[i] <= 1'b0;
          end else if (queue_cnt_reg[i] == {1'b0, queue_reg}) begin
            shdn_reg[i] <= 1'b1;
          end else begin
            queue_cnt_reg[i] <= queue_cnt_reg[i] + 4'h1;
          end
        end
      end
    end
  end

  assign o_shutdown_output_o = 1'b0;
  assign o_shutdown_output_oe = |shdn_reg;

  // ----------------------------------------
  // Fan controller
  // ----------------------------------------
  reg [7:0] period_cnt_reg;
  reg [17:0] quiet_cnt_reg;
  reg [17:0] dev_cnt_reg;
  reg [7:0] loop_level_reg;
  wire open_loop;
  wire [8:0] diff;
  wire deviating;
  wire fail_armed;

  assign open_loop = config_reg[`TMF_CFG_OPEN_LOOP];
  assign diff = (measured_reg > target_reg) ? {1'b0, measured_reg - target_reg}
                                            : {1'b0, target_reg - measured_reg};
  assign deviating = diff > {3'h0, target_reg[7:2]};
  assign fail_armed = open_loop ? (open_level_reg != 8'h00) : (measured_reg == 8'hFF);

  // Tach period count in fan clock ticks, saturating at 255.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      period_cnt_reg <= 8'h00;
      measured_reg <= 8'hFF;
      quiet_cnt_reg <= 18'h00000;
    end else begin
      if (tach_fall) begin
        measured_reg <= period_cnt_reg;
        period_cnt_reg <= tick ? 8'h01 : 8'h00; // A tick in the fall cycle opens the next period.
      end else if (tick) begin
        if (period_cnt_reg != 8'hFF)
          period_cnt_reg <= period_cnt_reg + 8'h01;
        else
          measured_reg <= 8'hFF; // A stalled fan reads as the longest period.
      end
      if (tach_change)
        quiet_cnt_reg <= 18'h00000;
      else if (tick && quiet_cnt_reg != FAIL_TICKS)
        quiet_cnt_reg <= quiet_cnt_reg + 18'h00001;
    end
  end

  // Closed loop nudges the level one step per tach period, or one per tick while stalled; too coarse a gain
  // would hunt, so slow settling is accepted here.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      loop_level_reg <= 8'h00;
      dev_cnt_reg <= 18'h00000;
    end else begin
      if (target_reg == 8'hFF)
        loop_level_reg <= 8'h00;
      else if ((tach_fall || (tick && period_cnt_reg == 8'hFF)) &&
               (period_cnt_reg > target_reg) && loop_level_reg != 8'hFF)
        loop_level_reg <= loop_level_reg + 8'h01;
      else if (tach_fall && period_cnt_reg < target_reg && loop_level_reg != 8'h00)
        loop_level_reg <= loop_level_reg - 8'h01;
      if (!deviating || open_loop || !config_reg[`TMF_CFG_OOC_EN])
        dev_cnt_reg <= 18'h00000;
      else if (tick && dev_cnt_reg != OOC_TICKS)
        dev_cnt_reg <= dev_cnt_reg + 18'h00001;
    end
  end

  // Drive code and pulses-per-revolution decode for the output stage.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_fan_drive_output <= 8'h00;
      o_pulses_per_rev <= 5'd2;
    end else begin
      o_fan_drive_output <= open_loop ? open_level_reg : loop_level_reg;
      o_pulses_per_rev <= 5'd2 << ppr_reg;
    end
  end

  // ----------------------------------------
  // Fan events and alert
  // ----------------------------------------
  always @* begin
    fail_event = config_reg[`TMF_CFG_FAIL_EN] && fail_armed && (quiet_cnt_reg == FAIL_TICKS);
    ooc_event = (dev_cnt_reg == OOC_TICKS);
  end

  // Fan flags clear on a status read, but a new event in that cycle wins.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      fan_fail_reg <= 1'b0;
      ooc_reg <= 1'b0;
      alert_reg <= 1'b0;
    end else begin
      fan_fail_reg <= fail_event | (fan_fail_reg & ~wr_status_rd);
      ooc_reg <= ooc_event | (ooc_reg & ~wr_status_rd);
      if (!config_reg[`TMF_CFG_MASK] && (|status[6:0]))
        alert_reg <= 1'b1;
      else if (i_alert_ack)
        alert_reg <= 1'b0;
    end
  end

  assign o_alert_o = 1'b0;
  assign o_alert_oe = alert_reg;

endmodule // tmf_core

// ### tmf_defines.vh
`ifndef TMF_DEFINES_VH
`define TMF_DEFINES_VH
// Function
// - Temperatures are 11-bit two's complement: sign, seven integer, three eighth-degree bits.
// - Every start converts all three channels, results published together at the end.
// - Status bit 7 is high while converting; previous results stay readable.
// - Rate register low three bits: 000 is 0.0625 Hz doubling to 8 Hz, default 1 Hz.
// - A one-shot command while stopped runs exactly one three-channel sequence.
// - Each sensor has a four-bit signed half-degree offset added to its reading.
// - Open diode sampled at conversion start raises alert and freezes that reading.
// - No diode fault is reported after reset until a conversion has started.
// - Open-diode faults of sensors one, two, three show in status bits 3, 2, 1.
// - A shorted diode at conversion start loads that reading with minus 128 degrees.
// - Sensor two threshold comes from the pin divider: 72 to 102 degrees, 2-degree steps.
// - Sensor one and three critical limits are separate eight-bit writable registers.
// - Shutdown when sensor one/three exceed limit or sensor two reaches threshold; output low.
// - Shutdown status bits 2, 1, 0 flag sensors three, two, one in shutdown.
// - Shutdown output asserts after queue code plus one consecutive out-of-limit results.
// - Configuration bit 1 selects open or closed loop; closed loop after reset.
// - Open loop drives the fan stage with the eight-bit open-loop level.
// - Closed loop regulates so the tach period count matches the target count.
// - Measured fan clock count between tach falling edges is readable, eight bits.
// - Pulses-per-revolution field decodes 00, 01, 10, 11 to 2, 4, 8, 16.
// - In closed loop, a target count of 255 stops the fan.
// - Fan fail: no tach transition for 0.7 s sets status bit 6 and alert.
// - Speed off target by 25 percent for 6 s sets status bit 5 and alert.
// - Alert follows any non-busy status bit and stays latched until alert response read.

// Command codes.
`define TMF_CMD_STATUS 8'h02
`define TMF_CMD_CONFIG 8'h03
`define TMF_CMD_SHDN_STATUS 8'h08
`define TMF_CMD_RATE 8'h0A
`define TMF_CMD_ONE_SHOT 8'h0F
`define TMF_CMD_TARGET 8'h10
`define TMF_CMD_MEASURED 8'h11
`define TMF_CMD_OPEN_LEVEL 8'h12
`define TMF_CMD_OFFSET1 8'h16
`define TMF_CMD_OFFSET2 8'h17
`define TMF_CMD_OFFSET3 8'h18
`define TMF_CMD_PPR 8'h19
`define TMF_CMD_QUEUE 8'h33
`define TMF_CMD_CRIT1 8'h35
`define TMF_CMD_CRIT3 8'h36

// Field positions.
`define TMF_ST_BUSY 7
`define TMF_ST_FAN_FAIL 6
`define TMF_ST_OOC 5
`define TMF_CFG_OPEN_LOOP 1
`define TMF_CFG_OOC_EN 4
`define TMF_CFG_FAIL_EN 5
`define TMF_CFG_STOP 6
`define TMF_CFG_MASK 7

// Reset values.
`define TMF_RST_CONFIG 8'h00
`define TMF_RST_RATE 8'h04
`define TMF_RST_TARGET 8'h80
`define TMF_RST_CRIT 8'h64

// Timing in 32.768 kHz ticks: 8 Hz interval, 0.7 s and 6 s windows (rounded down).
`define TMF_FAST_INTERVAL_TICKS 20'h01000
`define TMF_FAIL_TICKS 22937
`define TMF_OOC_TICKS 196608
`define TMF_SHORT_VALUE 11'h400
`define TMF_HW_BASE 8'h48
`endif

// ### tmf_core_monitor.sv
module tmf_core_monitor (
  // Clock, reset and register port.
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_wdata,
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [7:0] o_cmd_rdata,
  // Converter link and results.
  input wire logic o_adc_start,
  input wire logic [1:0] o_adc_chan,
  input wire logic i_adc_done,
  input wire logic [10:0] o_temp_first,
  input wire logic [10:0] o_temp_second,
  input wire logic [10:0] o_temp_third,
  // Fan and open-drain pins.
  input wire logic [7:0] o_fan_drive_output,
  input wire logic [4:0] o_pulses_per_rev,
  input wire logic o_shutdown_output_o,
  input wire logic o_alert_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ------
  // Shadow registers
  // ------
  logic [7:0] crit_reg;
  logic [7:0] lvl_reg;
  logic open_reg;
  logic halt_reg;
  // Shadows follow host writes only, so the checker never depends on core internals.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      crit_reg <= 8'h64;
      lvl_reg <= 8'h00;
      open_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else if (i_cmd_wr) begin
      if (i_cmd_addr == 8'h35) crit_reg <= i_cmd_wdata;
      if (i_cmd_addr == 8'h12) lvl_reg <= i_cmd_wdata;
      if (i_cmd_addr == 8'h03) open_reg <= i_cmd_wdata[1];
      if (i_cmd_addr == 8'h10) halt_reg <= (i_cmd_wdata == 8'hFF);
    end
  end
  // ------
  // Properties
  // ------
  sequence s_mid_done;
    i_adc_done && o_adc_chan != 2'd2;
  endsequence
  sequence s_last_done;
    i_adc_done && o_adc_chan == 2'd2;
  endsequence
  chk_start_pulse: assert property (o_adc_start |=> !o_adc_start)
    else $error("converter start longer than one cycle");
  chk_chan_step: assert property (s_mid_done |-> ##2
    (o_adc_start && o_adc_chan == $past(o_adc_chan, 2) + 2'd1))
    else $error("next channel not requested in order");
  chk_publish_late: assert property (s_last_done |=> $stable({o_temp_first,
    o_temp_second, o_temp_third})) else $error("results changed before publish");
  chk_publish_cause: assert property (!$stable({o_temp_first, o_temp_second,
    o_temp_third}) |-> $past(i_adc_done && o_adc_chan == 2'd2, 2))
    else $error("results changed outside publish");
  chk_ppr_code: assert property (o_pulses_per_rev inside {5'd2, 5'd4, 5'd8, 5'd16})
    else $error("pulses per revolution not a legal value");
  chk_drain_low: assert property (!o_shutdown_output_o && !o_alert_o)
    else $error("open-drain pin driven high");
  chk_crit_read: assert property (i_cmd_rd && i_cmd_addr == 8'h35 |=>
    o_cmd_rdata == crit_reg) else $error("critical limit read back wrong");
  chk_rdata_hold: assert property (!i_cmd_rd |=> $stable(o_cmd_rdata))
    else $error("read data moved without a read");
  chk_open_level: assert property (open_reg && i_cmd_wr && i_cmd_addr == 8'h12
    |-> ##[2:3] o_fan_drive_output == lvl_reg) else $error("open-loop level not driven");
  chk_fan_stop: assert property ((halt_reg && !open_reg) [*4] |->
    o_fan_drive_output == 8'h00) else $error("fan not stopped at target 255");
endmodule // tmf_core_monitor

// ### tmf_afe_model.sv
module tmf_afe_model (
  // Clock and request from the core.
  input wire logic i_mclk,
  input wire logic i_start,
  input wire logic [1:0] i_chan,
  // Per-channel readings and answer delay.
  input wire logic [32:0] i_vals,
  input wire logic [7:0] i_delay,
  // Answer to the core.
  output logic o_done,
  output logic [10:0] o_result
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_cnt = -1;
  logic [10:0] last = 11'h000;
  // Between answers the result lines are not held, so they show the inverse of the last
  // value; a core that samples them outside the done pulse picks up garbage.
  always @(posedge i_mclk) begin
    o_done <= 1'b0;
    o_result <= ~last;
    if (i_start) begin
      wait_cnt <= int'(i_delay);
    end else if (wait_cnt == 0) begin
      last <= i_vals[11 * i_chan +: 11];
      o_done <= 1'b1;
      o_result <= i_vals[11 * i_chan +: 11];
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule // tmf_afe_model

// ### test_thermal_monitor_fan_control.sv
module test_thermal_monitor_fan_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, ack, adc_start, done, fclk, tach, sd_o, sd_oe, al_o, al_oe;
  logic [7:0] addr, wdata, rdata, fan, v, crit, dly;
  logic [1:0] chan;
  logic [2:0] dopen, dshort, q;
  logic [3:0] hwc;
  logic [4:0] ppr;
  logic [10:0] res, t1, t2, t3;
  logic [10:0] raw [3];
  logic [3:0] off [3];
  logic [7:0] ra [6] = '{8'h0A, 8'h10, 8'h35, 8'h36, 8'h03, 8'h40};
  logic [7:0] rv [6] = '{8'h04, 8'h80, 8'h64, 8'h64, 8'h00, 8'h00};
  logic [31:0] seed = 32'd42;
  int n_fail = 0, check_count = 0, n_starts = 0, seq_cyc = 0, cyc = 0, tach_n = 0, t0;
  tmf_core #(.FAIL_TICKS(20), .OOC_TICKS(40)) uut (.i_mclk(clk), .i_rst(rst),
    .i_cmd_addr(addr), .i_cmd_wdata(wdata), .i_cmd_wr(wr), .i_cmd_rd(rd), .o_cmd_rdata(rdata),
    .i_alert_ack(ack), .o_adc_start(adc_start), .o_adc_chan(chan), .i_adc_done(done),
    .i_adc_result(res), .i_diode_open(dopen), .i_diode_short(dshort),
    .i_hw_threshold_code(hwc), .o_temp_first(t1), .o_temp_second(t2), .o_temp_third(t3),
    .i_fan_clk(fclk), .i_tachometer_input(tach), .o_fan_drive_output(fan),
    .o_pulses_per_rev(ppr), .o_shutdown_output_o(sd_o), .o_shutdown_output_oe(sd_oe),
    .o_alert_o(al_o), .o_alert_oe(al_oe));
  tmf_afe_model u_afe (.i_mclk(clk), .i_start(adc_start), .i_chan(chan),
    .i_vals({raw[2], raw[1], raw[0]}), .i_delay(dly), .o_done(done), .o_result(res));
  // ------
  // Clocks, tachometer and bookkeeping
  // ------
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // The fan clock is offset so its edges never line up with the core clock.
  initial begin
    fclk = 0;
    #7;
    forever #100 fclk = ~fclk;
  end
  // Tachometer falls every tach_n fan clock periods while tach_n is set.
  always begin
    @(posedge fclk);
    if (tach_n > 2) begin
      repeat (tach_n - 3) @(posedge fclk);
      #3 tach = 0;
      repeat (2) @(posedge fclk);
      #3 tach = 1;
    end
  end
  // Count requests, note each sequence start and cut a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (adc_start) n_starts <= n_starts + 1;
    if (adc_start && chan == 2'd0) seq_cyc <= cyc;
    if (cyc == 90000) begin
      $display("timeout reached");
      n_fail++;
      end_sim();
    end
  end
  // ------
  // Tasks
  // ------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Offset is in half degrees, four result steps each; the sum saturates.
  function automatic logic [10:0] exp_t(input logic [10:0] r, input logic [3:0] o);
    int s;
    s = int'($signed(r)) + 4 * int'($signed(o));
    if (s > 1023) s = 1023;
    if (s < -1024) s = -1024;
    return 11'(s);
  endfunction
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 addr = a;
    wdata = d;
    wr = 1;
    @(posedge clk);
    #2 wr = 0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #2 addr = a;
    rd = 1;
    @(posedge clk);
    #2 rd = 0;
    @(posedge clk);
    #2 d = rdata;
  endtask
  // One-shot conversion with the bench readings; waits for busy to drop.
  task automatic conv();
    int n0;
    logic [32:0] pv;
    logic [7:0] s;
    n0 = n_starts;
    pv = {t1, t2, t3};
    dly = 8'(8 + rnd() % 12);
    wr_reg(8'h0F, 8'h00);
    rd_reg(8'h02, s);
    chk(s[7], 1'b1);
    chk({t1, t2, t3}, pv);
    for (int i = 0; i < 300 && s[7]; i++) rd_reg(8'h02, s);
    repeat (20) @(posedge clk);
    chk(n_starts - n0, 3);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    rst = 1;
    {wr, rd, ack, tach, addr, wdata, dshort, hwc, dly} = 0;
    tach = 1;
    dopen = 3'b100;
    raw = '{11'h000, 11'h000, 11'h000};
    repeat (10) @(posedge clk);
    #2 rst = 0;
    rd_reg(8'h02, v);
    chk(v[3:1], 3'b000);
    chk(ppr, 5'd2);
    for (int i = 0; i < 6; i++) begin
      rd_reg(ra[i], v);
      chk(v, rv[i]);
    end
    wr_reg(8'h03, 8'h40);
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h19, 8'(c));
      repeat (3) @(posedge clk);
      chk(ppr, 5'd2 << c);
    end
    for (int i = 0; i < 6; i++) begin
      crit = 8'(rnd());
      wr_reg(ra[2 + i % 2], crit);
      rd_reg(ra[2 + i % 2], v);
      chk(v, crit);
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      off[i] = 4'(rnd());
      raw[i] = 11'(rnd());
      wr_reg(8'h16 + 8'(i), {4'h0, off[i]});
    end
    conv();
    chk(t1, exp_t(raw[0], off[0]));
    chk(t2, exp_t(raw[1], off[1]));
    chk(t3, 11'h000);
    rd_reg(8'h02, v);
    chk(v[3:1], 3'b001);
    chk(al_oe, 1'b1);
    dopen = 3'b000;
    dshort = 3'b100;
    raw[0] = 11'(rnd());
    conv();
    chk(t3, 11'h400);
    chk(t1, exp_t(raw[0], off[0]));
    rd_reg(8'h02, v);
    chk(v[3:1], 3'b000);
    chk(al_oe, 1'b1);
    @(posedge clk);
    #2 ack = 1;
    @(posedge clk);
    #2 ack = 0;
    repeat (2) @(posedge clk);
    chk(al_oe, 1'b0);
    dshort = 3'b000;
    $display("test conversion done");
    for (int i = 0; i < 3; i++) wr_reg(8'h16 + 8'(i), 8'h00);
    crit = 8'(rnd() % 100);
    q = 3'(rnd() % 4);
    hwc = 4'(rnd());
    wr_reg(8'h35, crit);
    wr_reg(8'h36, 8'h7F);
    wr_reg(8'h33, {5'h00, q});
    raw = '{11'h000, 11'h000, 11'h000};
    conv();
    chk(sd_oe, 1'b0);
    raw[0] = {crit, 3'h7};
    raw[1] = {8'(72 + 2 * hwc), 3'h0};
    for (int k = 0; k <= q; k++) begin
      conv();
      chk(sd_oe, k == q);
    end
    rd_reg(8'h08, v);
    chk(v[2:0], 3'b010);
    raw[0] = {crit + 8'h01, 3'h0};
    wr_reg(8'h33, 8'h00);
    conv();
    rd_reg(8'h08, v);
    chk(v[2:0], 3'b011);
    $display("test shutdown done");
    wr_reg(8'h03, 8'h62);
    crit = 8'(rnd()) | 8'h01;
    wr_reg(8'h12, crit);
    repeat (4) @(posedge clk);
    chk(fan, crit);
    repeat (400) @(posedge clk);
    rd_reg(8'h02, v);
    chk(v[6], 1'b1);
    chk(al_oe, 1'b1);
    wr_reg(8'h03, 8'h50);
    tach_n = 20 + rnd() % 40;
    repeat (32 * tach_n) @(posedge clk);
    rd_reg(8'h11, v);
    chk(v, tach_n);
    rd_reg(8'h02, v);
    chk(v[5], 1'b1);
    wr_reg(8'h10, 8'hFF);
    repeat (8) @(posedge clk);
    chk(fan, 8'h00);
    tach_n = 0;
    $display("test fan done");
    wr_reg(8'h0A, 8'h07);
    wr_reg(8'h03, 8'h00);
    for (int k = 0; k < 2; k++) begin
      t0 = seq_cyc;
      for (int i = 0; i < 40000 && seq_cyc == t0; i++) @(posedge clk);
    end
    chk(seq_cyc - t0 >= 32760 && seq_cyc - t0 <= 32776, 1'b1);
    $display("test rate done");
    end_sim();
  end
endmodule // test_thermal_monitor_fan_control
bind tmf_core tmf_core_monitor u_mon (.i_mclk, .i_rst, .i_cmd_addr, .i_cmd_wdata, .i_cmd_wr,
  .i_cmd_rd, .o_cmd_rdata, .o_adc_start, .o_adc_chan, .i_adc_done, .o_temp_first,
  .o_temp_second, .o_temp_third, .o_fan_drive_output, .o_pulses_per_rev,
  .o_shutdown_output_o, .o_alert_o);
